//--- hw/dgp_pkg.sv
// Notes on behaviour
// R1: port a has five two-way pins, each with output latch and direction bit.
// R2: direction one floats the driver (input); zero drives the latch onto the pin.
// R3: data reads return pin levels; data writes update only the output latch.
// R4: every data write is read-modify-write: pins read, value merged, latch stored.
// R5: port a bit 4 is schmitt timer clock input and open-drain output only.
// R6: low four port a pins select analog or reference under a three-bit field.
// R7: after power-on the four analog-capable pins are analog and read as zero.
// R8: software keeps direction set to one on every pin used as analog input.
// R9: port b has eight two-way pins with latch and same-polarity direction bit.
// R10: port b weak pull-ups all enabled by clearing active-low bit 7 of option.
// R11: a port b pull-up is off whenever that pin is an output.
// R12: power-on reset leaves all port b pull-ups disabled.
// R13: an enabled peripheral may override a pin direction to output or input.
// R14: software avoids read-modify-write of port b direction during overrides.
// R15: only upper four port b inputs take part in change detection.
// R16: inputs compare against value latched at last port b read; or sets flag.
// R17: the port change interrupt can wake the device from sleep.
// R18: any read or write of port b data refreshes the compare latch.
// R19: flag keeps setting while mismatch lasts; software ends mismatch then clears.
// R20: software using change interrupt avoids polling port b data.
// R21: a pin taken by an enabled peripheral is not general i/o.
// R22: a pin selected analog always reads zero on its digital path.
// R23: change flag sets on mismatch cycle and holds until software clears it.
package dgp_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int PA_W = 5;
   localparam int PA_DIR_W = 6;
   localparam int PB_W = 8;
   localparam int AN_W = 4;
   localparam int CFG_W = 3;
   localparam int REG_W = 8;
   localparam int OD_BIT = 4;
   localparam int CHG_LO = 4;
   localparam int PU_BIT = 7;
   localparam int FLAG_BIT = 0;
   localparam int IEN_BIT = 3;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PA_DATA = 8'h05;
   localparam logic [7:0] IDX_PB_DATA = 8'h06;
   localparam logic [7:0] IDX_ICTL = 8'h0b;
   localparam logic [7:0] IDX_OPTION = 8'h81;
   localparam logic [7:0] IDX_PA_DIR = 8'h85;
   localparam logic [7:0] IDX_PB_DIR = 8'h86;
   localparam logic [7:0] IDX_AN_CFG = 8'h9f;
   localparam logic [PA_DIR_W-1:0] PA_DIR_RST = 6'h3f;
   localparam logic [PB_W-1:0] PB_DIR_RST = 8'hff;
   localparam logic [REG_W-1:0] OPTION_RST = 8'hff;
   localparam logic [CFG_W-1:0] AN_CFG_RST = 3'h0;
endpackage

//--- hw/dgp_sync.sv
`timescale 1ns/100ps
module dgp_sync #(
   parameter int W = 1
) (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // sync reset, high
   input wire logic [W-1:0] d, // asynchronous levels
   output logic [W-1:0] q // synchronised levels
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

//--- hw/dgp_top.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module dgp_top (
   input wire logic core_clk, // 200 MHz core clock
   input wire logic sys_rst, // sync reset, high
   // ==========================================
   // avalon-mm slave
   input wire logic [dgp_pkg::ADDR_W-1:0] address, // byte address
   input wire logic read, // read request
   input wire logic write, // write request
   input wire logic [3:0] byteenable, // byte lanes
   input wire logic [dgp_pkg::DATA_W-1:0] writedata, // write data
   output logic [dgp_pkg::DATA_W-1:0] readdata, // read data
   output logic waitrequest, // stall
   // ==========================================
   // port a pins
   input wire logic [dgp_pkg::PA_W-1:0] pa_in, // pin levels
   output logic [dgp_pkg::PA_W-1:0] pa_out, // pin drive value
   output logic [dgp_pkg::PA_W-1:0] pa_oe_n, // drive enable, low
   output logic timer_ext_clock_in, // timer clock from bit 4
   output logic [dgp_pkg::AN_W-1:0] analog_sel, // pin is analog
   output logic vref_sel, // bit 3 is reference
   // ==========================================
   // port b pins
   input wire logic [dgp_pkg::PB_W-1:0] pb_in, // pin levels
   output logic [dgp_pkg::PB_W-1:0] pb_out, // pin drive value
   output logic [dgp_pkg::PB_W-1:0] pb_oe_n, // drive enable, low
   output logic [dgp_pkg::PB_W-1:0] pb_pullup_en, // weak pull-up on
   input wire logic [dgp_pkg::PB_W-1:0] periph_ovr_en, // peripheral owns pin
   input wire logic [dgp_pkg::PB_W-1:0] periph_ovr_dir, // forced dir, 1 input
   input wire logic [dgp_pkg::PB_W-1:0] periph_out, // peripheral drive
   // ==========================================
   // events
   output logic change_irq, // flag and enable
   output logic wake_req // leave sleep
);
   import dgp_pkg::*;

   // ==========================================
   // pin sampling
   logic [PA_W-1:0] pa_pins;
   logic [PB_W-1:0] pb_pins;

   dgp_sync #(.W(PA_W + PB_W)) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .d({pb_in, pa_in}),
      .q({pb_pins, pa_pins})
   );

   // ==========================================
   // state
   logic [PA_W-1:0] pa_latch;
   logic [PA_DIR_W-1:0] pa_dir;
   logic [PB_W-1:0] pb_latch;
   logic [PB_W-1:0] pb_dir;
   logic [REG_W-1:0] option;
   logic [CFG_W-1:0] an_cfg;
   logic chg_flag;
   logic chg_ien;
   logic [PB_W-1:CHG_LO] cmp;
   logic ack;

   // ==========================================
   // bus handshake: one wait state
   logic req;
   logic acc;
   logic [7:0] idx;
   logic idx_ok;

   assign req = read | write;
   assign waitrequest = req & ~ack;
   assign acc = req & ack;
   assign idx = address[ADDR_W-1:2];
   assign idx_ok = (address[1:0] == 2'h0);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   logic sel_pa;
   logic sel_pb;
   logic sel_pa_dir;
   logic sel_pb_dir;
   logic sel_opt;
   logic sel_cfg;
   logic sel_ictl;

   assign sel_pa = idx_ok && idx == IDX_PA_DATA;
   assign sel_pb = idx_ok && idx == IDX_PB_DATA;
   assign sel_pa_dir = idx_ok && idx == IDX_PA_DIR;
   assign sel_pb_dir = idx_ok && idx == IDX_PB_DIR;
   assign sel_opt = idx_ok && idx == IDX_OPTION;
   assign sel_cfg = idx_ok && idx == IDX_AN_CFG;
   assign sel_ictl = idx_ok && idx == IDX_ICTL;

   logic wr_lo;

   assign wr_lo = acc & write & byteenable[0];

   // ==========================================
   // analog pin selection
   function automatic logic [AN_W-1:0] an_mask(input logic [CFG_W-1:0] c);
      case (c)
         3'h0: an_mask = 4'hf;
         3'h1: an_mask = 4'hf;
         3'h2: an_mask = 4'h7;
         3'h3: an_mask = 4'h3;
         3'h4: an_mask = 4'h1;
         default: an_mask = 4'h0;
      endcase
   endfunction

   assign analog_sel = an_mask(an_cfg); // [R6]
   assign vref_sel = (an_cfg == 3'h1); // [R6]

   logic [PA_W-1:0] pa_digital;

   // analog pins read zero at all times, not just after reset
   assign pa_digital = pa_pins & ~{1'b0, analog_sel}; // [R7] [R22]

   // ==========================================
   // effective port b direction
   logic [PB_W-1:0] pb_eff_dir;

   assign pb_eff_dir = (periph_ovr_en & periph_ovr_dir) |
                       (~periph_ovr_en & pb_dir); // [R13] [R21]

   // ==========================================
   // pin drivers, one entry per pin
   genvar gi;
   generate
      for (gi = 0; gi < PA_W; gi++) begin : g_pa
         if (gi == OD_BIT) begin : g_od
            // open drain: never drives high
            assign pa_out[gi] = 1'b0; // [R5]
            assign pa_oe_n[gi] = pa_dir[gi] | pa_latch[gi]; // [R5]
         end else begin : g_pp
            assign pa_out[gi] = pa_latch[gi]; // [R2]
            assign pa_oe_n[gi] = pa_dir[gi]; // [R1] [R2]
         end
      end
      for (gi = 0; gi < PB_W; gi++) begin : g_pb
         assign pb_oe_n[gi] = pb_eff_dir[gi]; // [R9] [R13]
         assign pb_out[gi] = periph_ovr_en[gi] ? periph_out[gi]
                                               : pb_latch[gi]; // [R21]
         assign pb_pullup_en[gi] = ~option[PU_BIT] & pb_eff_dir[gi]; // [R10] [R11]
      end
   endgenerate

   assign timer_ext_clock_in = pa_pins[OD_BIT]; // [R5]

   // ==========================================
   // data latches: writes are read-modify-write
   // an unenabled low lane stores the pin levels back
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pa_latch <= '0;
      end else if (acc && write && sel_pa) begin
         pa_latch <= byteenable[0] ? writedata[PA_W-1:0] : pa_pins; // [R3] [R4]
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pb_latch <= '0;
      end else if (acc && write && sel_pb) begin
         pb_latch <= byteenable[0] ? writedata[PB_W-1:0] : pb_pins; // [R4] [R9]
      end
   end

   // ==========================================
   // direction, option and analog config
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pa_dir <= PA_DIR_RST;
         pb_dir <= PB_DIR_RST;
      end else begin
         if (wr_lo && sel_pa_dir) begin
            pa_dir <= writedata[PA_DIR_W-1:0]; // [R1]
         end
         // stored value only; overrides act on the pins
         if (wr_lo && sel_pb_dir) begin
            pb_dir <= writedata[PB_W-1:0]; // [R9]
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         option <= OPTION_RST; // [R12]
      end else if (wr_lo && sel_opt) begin
         option <= writedata[REG_W-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         an_cfg <= AN_CFG_RST; // [R7]
      end else if (wr_lo && sel_cfg) begin
         an_cfg <= writedata[CFG_W-1:0]; // [R6]
      end
   end

   // ==========================================
   // change detection
   logic [PB_W-1:CHG_LO] mism_bits;
   logic mismatch;
   logic pb_access;
   logic flag_clr;

   assign mism_bits = (pb_pins[PB_W-1:CHG_LO] ^ cmp) &
                      pb_eff_dir[PB_W-1:CHG_LO]; // [R15] [R16]
   assign mismatch = |mism_bits; // [R16]
   assign pb_access = acc && sel_pb;
   assign flag_clr = wr_lo && sel_ictl && !writedata[FLAG_BIT];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmp <= '0;
      end else if (pb_access) begin
         cmp <= pb_pins[PB_W-1:CHG_LO]; // [R18]
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         chg_flag <= 1'b0;
      end else if (mismatch) begin
         chg_flag <= 1'b1; // [R19] [R23]
      end else if (flag_clr) begin
         chg_flag <= 1'b0; // [R19]
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         chg_ien <= 1'b0;
      end else if (wr_lo && sel_ictl) begin
         chg_ien <= writedata[IEN_BIT];
      end
   end

   assign change_irq = chg_flag & chg_ien;
   assign wake_req = chg_flag & chg_ien; // [R17]

   // ==========================================
   // read data, loaded in the wait cycle
   logic [REG_W-1:0] next_rd;

   always_comb begin
      next_rd = '0;
      case (1'b1)
         sel_pa: next_rd = {3'h0, pa_digital}; // [R3] [R7]
         sel_pb: next_rd = pb_pins; // [R3]
         sel_pa_dir: next_rd = {2'h0, pa_dir};
         sel_pb_dir: next_rd = pb_dir;
         sel_opt: next_rd = option;
         sel_cfg: next_rd = {5'h0, an_cfg};
         sel_ictl: begin
            next_rd[FLAG_BIT] = chg_flag;
            next_rd[IEN_BIT] = chg_ien;
         end
         default: next_rd = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         readdata <= '0;
      end else if (read && !ack) begin
         readdata <= {24'h0, next_rd};
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_bus_one_wait: assert property ( // [R3]
      req && !ack |=> !waitrequest ##1 (!req || waitrequest))
      else $error("bus answer not after one wait state");

   a_analog_reads_zero: assert property ( // [R22]
      acc && read && sel_pa |-> (readdata[AN_W-1:0] & analog_sel) == '0)
      else $error("analog pin read as nonzero");

   a_open_drain_low: assert property ( // [R5]
      !pa_oe_n[OD_BIT] |-> !pa_out[OD_BIT] && !pa_dir[OD_BIT]
                           && !pa_latch[OD_BIT])
      else $error("open drain pin drives wrongly");

   a_rmw_lane_off: assert property ( // [R4]
      acc && write && sel_pa && !byteenable[0] |=> pa_latch == $past(pa_pins))
      else $error("latch not loaded from pins");

   a_pullup_gate: assert property ( // [R11]
      ((pb_pullup_en & ~pb_eff_dir) == '0) &&
      (!option[PU_BIT] || (pb_pullup_en == '0)))
      else $error("pull-up on for output or disabled");

   a_flag_sets: assert property ( // [R23]
      mismatch |=> chg_flag)
      else $error("mismatch did not set flag");

   a_flag_holds: assert property ( // [R19]
      chg_flag && !flag_clr |=> chg_flag)
      else $error("flag dropped without clear");

   a_cmp_refresh: assert property ( // [R18]
      pb_access |=> cmp == $past(pb_pins[PB_W-1:CHG_LO]) ##1 1'b1)
      else $error("compare latch not refreshed");

   a_wake_follows: assert property ( // [R17]
      $rose(chg_flag) && chg_ien |-> wake_req && change_irq)
      else $error("wake not raised with flag");

   a_override_dir: assert property ( // [R13]
      periph_ovr_en[0] |-> pb_oe_n[0] == periph_ovr_dir[0])
      else $error("peripheral override ignored");

endmodule

//--- sim/dgp_pin_model.sv
`timescale 1ns/100ps
// ==========================================
// board side of both ports
module dgp_pin_model (
   input wire logic [dgp_pkg::PA_W-1:0] pa_out, // device drive value
   input wire logic [dgp_pkg::PA_W-1:0] pa_oe_n, // device drive enable
   input wire logic [dgp_pkg::PB_W-1:0] pb_out, // device drive value
   input wire logic [dgp_pkg::PB_W-1:0] pb_oe_n, // device drive enable
   input wire logic [dgp_pkg::PB_W-1:0] pb_pullup_en, // weak pull-up
   input wire logic [dgp_pkg::PA_W-1:0] ext_a, // board level, port a
   input wire logic [dgp_pkg::PB_W-1:0] ext_b, // board level, port b
   input wire logic [dgp_pkg::PB_W-1:0] ext_drv, // board drives port b
   output logic [dgp_pkg::PA_W-1:0] pa_in, // resolved level
   output logic [dgp_pkg::PB_W-1:0] pb_in // resolved level
);
   import dgp_pkg::*;
   // open-drain bit floats to the board level when not pulled low
   assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & ext_a);
   // floating pin without pull-up shows the inverse, never a stale value
   assign pb_in = (~pb_oe_n & pb_out) |
      (pb_oe_n & ((ext_drv & ext_b) | (~ext_drv & (pb_pullup_en | ~ext_b))));
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps
module tb;
   import dgp_pkg::*;
   logic core_clk, sys_rst, read, write, change_irq, wake_req, timer_ext_clock_in, vref_sel;
   logic [ADDR_W-1:0] address;
   logic [3:0] byteenable, analog_sel;
   logic [DATA_W-1:0] writedata, readdata;
   logic waitrequest;
   logic [PA_W-1:0] pa_in, pa_out, pa_oe_n, ext_a;
   logic [PB_W-1:0] pb_in, pb_out, pb_oe_n, pb_pullup_en, ext_b, ext_drv;
   logic [PB_W-1:0] periph_ovr_en, periph_ovr_dir, periph_out;
   int n_fail = 0;
   int checks = 0;
   localparam logic [3:0] AN_DEC [8] = '{4'hf, 4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h0, 4'h0};
   dgp_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
      .timer_ext_clock_in(timer_ext_clock_in), .analog_sel(analog_sel), .vref_sel(vref_sel),
      .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pullup_en),
      .periph_ovr_en(periph_ovr_en), .periph_ovr_dir(periph_ovr_dir),
      .periph_out(periph_out), .change_irq(change_irq), .wake_req(wake_req));
   dgp_pin_model pins (.pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
      .pb_pullup_en(pb_pullup_en), .ext_a(ext_a), .ext_b(ext_b), .ext_drv(ext_drv),
      .pa_in(pa_in), .pb_in(pb_in));
   // ==========================================
   // shared tasks
   task summarize;
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd,
      input logic [3:0] be, output logic [7:0] rd);
      @(posedge core_clk);
      address <= {idx, 2'b00};
      read <= ~wr_en;
      write <= wr_en;
      writedata <= {24'h0, wd};
      byteenable <= be;
      // no cycle limit here: only the watchdog ends a stalled wait
      do begin
         @(posedge core_clk);
      end while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be = 4'h1);
      logic [7:0] t;
      bus(1'b1, idx, d, be, t);
   endtask
   task rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] t;
      bus(1'b0, idx, 8'h00, 4'hf, t);
      chk(nm, t, exp);
   endtask
   // pin changes need two sync edges plus the flag edge
   task settle;
      repeat (4) @(posedge core_clk);
   endtask
   // ==========================================
   // scenarios
   task t_reset;
      rchk("pa_dir", IDX_PA_DIR, 8'h3f);
      rchk("pb_dir", IDX_PB_DIR, 8'hff);
      rchk("option", IDX_OPTION, 8'hff);
      rchk("an_cfg", IDX_AN_CFG, 8'h00);
      rchk("unmapped", 8'h40, 8'h00);
      chk("pullup", pb_pullup_en, 8'h00);
      chk("pa_oe_n", pa_oe_n, 5'h1f);
      chk("analog", analog_sel, 4'hf);
      rchk("pa_rst", IDX_PA_DATA, 8'h10);
   endtask
   task t_port_a;
      for (int c = 0; c < 8; c++) begin
         wr(IDX_AN_CFG, c[7:0]);
         settle();
         chk("an_dec", analog_sel, AN_DEC[c]);
         chk("vref", vref_sel, c == 1);
      end
      wr(IDX_PA_DIR, 8'h30);
      wr(IDX_PA_DATA, 8'h15);
      ext_a <= 5'h0a;
      settle();
      chk("pa_out", pa_out, 5'h05);
      chk("pa_oe", pa_oe_n, 5'h10);
      rchk("pa_pins", IDX_PA_DATA, 8'h05);
      ext_a <= 5'h1a;
      settle();
      chk("tclk", timer_ext_clock_in, 1'b1);
      rchk("pa_pins4", IDX_PA_DATA, 8'h15);
      wr(IDX_PA_DIR, 8'h20);
      settle();
      chk("od_float", pa_oe_n, 5'h10);
      wr(IDX_PA_DIR, 8'h3f);
      // bit 4 low at the pins so the stored latch pulls it low
      ext_a <= 5'h0a;
      settle();
      wr(IDX_PA_DATA, 8'h00, 4'h0);
      wr(IDX_PA_DIR, 8'h20);
      settle();
      chk("rmw_out", pa_out, 5'h0a);
      chk("od_low", pa_oe_n, 5'h00);
      wr(IDX_PA_DIR, 8'h23);
      wr(IDX_AN_CFG, 8'h03);
      settle();
      rchk("an_zero", IDX_PA_DATA, 8'h08);
   endtask
   task t_port_b;
      wr(IDX_OPTION, 8'h7f);
      wr(IDX_PB_DIR, 8'h0f);
      wr(IDX_PB_DATA, 8'ha5);
      ext_b <= 8'h5a;
      settle();
      chk("pb_oe", pb_oe_n, 8'h0f);
      chk("pull", pb_pullup_en, 8'h0f);
      rchk("pb_pins", IDX_PB_DATA, 8'haa);
      ext_drv <= 8'h00;
      settle();
      rchk("pb_pulled", IDX_PB_DATA, 8'haf);
      ext_drv <= 8'hff;
      periph_ovr_en <= 8'h81;
      periph_ovr_dir <= 8'h80;
      periph_out <= 8'h01;
      settle();
      chk("ovr_oe", pb_oe_n, 8'h8e);
      chk("ovr_out", pb_out, 8'h25);
      chk("ovr_pull", pb_pullup_en, 8'h8e);
      periph_ovr_en <= 8'h00;
      wr(IDX_OPTION, 8'hff);
   endtask
   task t_change;
      logic [7:0] t;
      // direction rewritten only once the override is gone
      wr(IDX_PB_DIR, 8'hff);
      ext_b <= 8'h00;
      settle();
      rchk("pb_ref", IDX_PB_DATA, 8'h00);
      wr(IDX_ICTL, 8'h00);
      wr(IDX_ICTL, 8'h01);
      ext_b <= 8'h04;
      settle();
      rchk("low_pin", IDX_ICTL, 8'h00);
      ext_b <= 8'h24;
      settle();
      chk("masked", change_irq, 1'b0);
      rchk("flag_set", IDX_ICTL, 8'h01);
      wr(IDX_ICTL, 8'h08);
      rchk("clr_hold", IDX_ICTL, 8'h09);
      chk("irq", change_irq, 1'b1);
      chk("wake", wake_req, 1'b1);
      wr(IDX_PB_DATA, 8'h00);
      wr(IDX_ICTL, 8'h08);
      rchk("clr_ok", IDX_ICTL, 8'h08);
      ext_b <= 8'h64;
      settle();
      bus(1'b0, IDX_PB_DATA, 8'h00, 4'hf, t);
      wr(IDX_ICTL, 8'h08);
      settle();
      chk("irq_off", change_irq, 1'b0);
      periph_ovr_en <= 8'h80;
      periph_ovr_dir <= 8'h00;
      periph_out <= 8'h00;
      settle();
      bus(1'b0, IDX_PB_DATA, 8'h00, 4'hf, t);
      periph_out <= 8'h80;
      settle();
      rchk("out_excl", IDX_ICTL, 8'h08);
   endtask
   // ==========================================
   // clock, reset and run
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      summarize();
   end
   initial begin
      sys_rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      byteenable = 4'h0;
      writedata = '0;
      ext_a = 5'h1f;
      ext_b = 8'h00;
      ext_drv = 8'hff;
      periph_ovr_en = 8'h00;
      periph_ovr_dir = 8'h00;
      periph_out = 8'h00;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      settle();
      t_reset();
      t_port_a();
      t_port_b();
      t_change();
      summarize();
   end
endmodule
